// *** testbench/eca_array_model.sv ***
`timescale 1ns/1ps
module eca_array_model (
   // Clock and blank state chosen by the bench.
   input  wire logic clk_in,
   input  wire logic pf_blank_in,
   input  wire logic ee_blank_in,
   // Erased reports toward the controller.
   output logic      pf_erased_out,
   output logic      ee_erased_out
);
   // Registered, so the controller never sees a same-cycle answer from the arrays.
   always_ff @(posedge clk_in) begin
      pf_erased_out <= pf_blank_in;
      ee_erased_out <= ee_blank_in;
   end
endmodule

// *** testbench/eeprom_command_arbiter_test.sv ***
`timescale 1ns/1ps
module eeprom_command_arbiter_test;
   import eca_pkg::*;
   logic        clk, rst, psel, pen, pwr, pfq, eeq, pfb, eeb, se;
   logic        pready, pslverr, pfg, eeg, ill, done, pfe, eee;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   eca_cl_t     eeop, pfop;
   int          fails, comparisons;
   eca_top eca_top_inst (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PF_RD_REQ_IN(pfq), .EE_RD_REQ_IN(eeq),
      .PF_ERASED_IN(pfe), .EE_ERASED_IN(eee), .PF_RD_GNT_OUT(pfg), .EE_RD_GNT_OUT(eeg),
      .ILLEGAL_ACCESS_OUT(ill), .EE_OP_OUT(eeop), .PF_OP_OUT(pfop), .CMD_DONE_OUT(done));
   eca_array_model eca_array_model_inst (.clk_in(clk), .pf_blank_in(pfb),
      .ee_blank_in(eeb), .pf_erased_out(pfe), .ee_erased_out(eee));
   // Every comparison is counted; a mismatch is printed at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic stat(input logic [31:0] exp);
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic launch(input logic [7:0] code, input logic [31:0] par);
      apb(1'b1, OFF_CMD, {24'h0000_00, code});
      apb(1'b1, OFF_PARAM, par);
      apb(1'b1, OFF_STATUS, 32'h0000_0080);
   endtask
   // A one-cycle read request; the collision flag must be low again the cycle after the answer.
   task automatic rdreq(input logic pf_side, input logic [1:0] exp);
      pfq <= pf_side;
      eeq <= !pf_side;
      @(posedge clk);
      pfq <= 1'b0;
      eeq <= 1'b0;
      @(posedge clk);
      chk({30'h0, pf_side ? pfg : eeg, ill}, {30'h0, exp});
      @(posedge clk);
      chk({31'h0, ill}, 32'h0000_0000);
   endtask
   task automatic op(input eca_cl_t c);
      int n;
      n = 0;
      while (eeop !== c && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk({29'h0, eeop}, {29'h0, c});
   endtask
   // Completion drops shortly after launch and returns within a bounded span.
   task automatic wait_done();
      int n;
      n = 0;
      repeat (3) @(posedge clk);
      chk({31'h0, done}, 32'h0000_0000);
      while (done !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, done}, 32'h0000_0001);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // The whole sequence needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      report_and_stop();
   end
   initial begin
      {rst, psel, pen, pwr, pfq, eeq, pfb, eeb} = 8'b1000_0011;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      stat(32'h0000_0080);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk({31'h0, se}, 32'h0000_0001);
      launch(CMD_ERS_SEC, 32'h0000_0000);
      stat(32'h0000_00A0);
      launch(CMD_ERS_SEC, 32'h0000_0000);
      stat(32'h0000_00A0);
      apb(1'b1, OFF_STATUS, 32'h0000_0030);
      stat(32'h0000_0080);
      apb(1'b1, OFF_CLKDIV, 32'h0000_0010);
      launch(8'h05, 32'h0000_0000);
      stat(32'h0000_00A0);
      apb(1'b1, OFF_STATUS, 32'h0000_0030);
      launch(CMD_FMARGIN, 32'h0000_0001);
      stat(32'h0000_00A0);
      apb(1'b1, OFF_STATUS, 32'h0000_0030);
      launch(CMD_ERS_ALL, 32'h0000_0000);
      stat(32'h0000_0090);
      apb(1'b1, OFF_STATUS, 32'h0000_0030);
      launch(CMD_ERS_SEC, 32'h0000_0000);
      rdreq(1'b1, 2'b10);
      op(CL_SECT);
      rdreq(1'b1, 2'b10);
      rdreq(1'b0, 2'b01);
      wait_done();
      launch(CMD_PRG_EE, 32'h0000_0001);
      op(CL_PROG);
      rdreq(1'b1, 2'b10);
      wait_done();
      launch(CMD_UMARGIN, 32'h0000_0001);
      wait_done();
      launch(CMD_PRG_EE, 32'h0000_0001);
      op(CL_PROG);
      rdreq(1'b1, 2'b01);
      wait_done();
      launch(CMD_UMARGIN, 32'h0000_0000);
      wait_done();
      apb(1'b1, OFF_PROT, 32'h0000_000F);
      launch(CMD_ERS_ALL, 32'h0000_0000);
      op(CL_MASS);
      chk({29'h0, pfop}, {29'h0, CL_MASS});
      rdreq(1'b1, 2'b01);
      wait_done();
      launch(CMD_ERS_BLK, 32'h0001_0000);
      op(CL_MASS);
      wait_done();
      stat(32'h0000_0080);
      pfb <= 1'b0;
      launch(CMD_VFY_ALL, 32'h0000_0000);
      wait_done();
      stat(32'h0000_0081);
      launch(CMD_VFY_BLK, 32'h0000_0000);
      wait_done();
      stat(32'h0000_0080);
      eeb <= 1'b0;
      launch(CMD_VFY_SEC, 32'h0000_0002);
      wait_done();
      stat(32'h0000_0081);
      launch(CMD_UNSEC, 32'h0000_0000);
      wait_done();
      stat(32'h0000_0081);
      apb(1'b1, OFF_PROT, 32'h0000_0000);
      launch(CMD_PROT_OV, {16'h0000, OVR_KEY});
      wait_done();
      apb(1'b0, OFF_PROT, 32'h0000_0000);
      chk(rd, 32'h0000_0010);
      report_and_stop();
   end
endmodule

// *** verilog/eca_cmd_check.sv ***
`timescale 1ns/1ps
module eca_cmd_check (
   // Command check side.
   eca_if.chk bus
);
   import eca_pkg::*;
   logic writes;

   // Decode the code into operation classes and check its preconditions.
   always_comb begin
      bus.access_error_flag    = 1'b0;
      bus.protection_violation_flag    = 1'b0;
      bus.ee_cl     = CL_NONE;
      bus.pf_cl     = CL_NONE;
      bus.vfy_ee    = 1'b0;
      bus.vfy_pf    = 1'b0;
      bus.two_phase = 1'b0;
      bus.key_ok    = (bus.param[15:0] == OVR_KEY);
      writes        = 1'b0;
      unique case (bus.code)
         CMD_VFY_ALL: begin
            bus.ee_cl  = CL_READ;
            bus.pf_cl  = CL_READ;
            bus.vfy_ee = 1'b1;
            bus.vfy_pf = 1'b1;
         end
         CMD_VFY_BLK: begin
            bus.ee_cl  = CL_READ;
            bus.vfy_ee = 1'b1;
         end
         CMD_ERS_ALL: begin
            writes    = 1'b1;
            bus.ee_cl = CL_MASS;
            bus.pf_cl = CL_MASS;
            bus.protection_violation_flag = ~&bus.prot;
         end
         CMD_ERS_BLK: begin
            writes = 1'b1;
            if (bus.param[PA_EEBLK]) begin
               bus.ee_cl  = CL_MASS;
               bus.protection_violation_flag = ~bus.prot[PR_EEOPEN];
            end else begin
               bus.pf_cl  = CL_MASS;
               bus.protection_violation_flag = ~&bus.prot[PR_PFOPEN:PR_LOWDIS];
            end
         end
         CMD_UNSEC: begin
            writes        = 1'b1;
            bus.ee_cl     = CL_MASS;
            bus.pf_cl     = CL_MASS;
            bus.vfy_ee    = 1'b1;
            bus.vfy_pf    = 1'b1;
            bus.two_phase = 1'b1;
         end
         CMD_UMARGIN: bus.ee_cl = CL_READ;
         CMD_FMARGIN: begin
            bus.ee_cl  = CL_READ;
            bus.access_error_flag = ~bus.special;
         end
         CMD_VFY_SEC: begin
            bus.ee_cl  = CL_READ;
            bus.vfy_ee = 1'b1;
            bus.access_error_flag = (bus.param[15:0] == 16'h0000);
         end
         CMD_PRG_EE: begin
            writes     = 1'b1;
            bus.ee_cl  = CL_PROG;
            bus.access_error_flag = (bus.param[2:0] == 3'h0) || (bus.param[2:0] > 3'h4);
         end
         CMD_ERS_SEC: begin
            writes    = 1'b1;
            bus.ee_cl = CL_SECT;
         end
         CMD_PROT_OV: bus.ee_cl = CL_READ;
         default: bus.access_error_flag = 1'b1;
      endcase
      // A write or erase before the divider is set must not run.
      if (writes && !bus.clkdiv_ok) begin
         bus.access_error_flag = 1'b1;
      end
   end
endmodule

// *** verilog/eca_collide.sv ***
`timescale 1ns/1ps
module eca_collide (
   // Concurrency check side.
   eca_if.col bus
);
   import eca_pkg::*;

   // Program flash reads may share time only with light EEPROM work.
   always_comb begin
      bus.pf_ok = 1'b0;
      if (bus.op_pf == CL_NONE) begin
         if (bus.op_ee == CL_NONE) begin
            bus.pf_ok = 1'b1;
         end else if (bus.pf_rd_cl == CL_READ) begin
            bus.pf_ok = (bus.op_ee != CL_MASS);
         end
      end
   end
endmodule

// *** verilog/eca_if.sv ***
`timescale 1ns/1ps
interface eca_if;
   import eca_pkg::*;
   // Command under check and its environment.
   logic [7:0]  code;
   logic [16:0] param;
   logic [3:0]  prot;
   logic        special;
   logic        clkdiv_ok;
   // Check results.
   logic        access_error_flag;
   logic        protection_violation_flag;
   eca_cl_t     ee_cl;
   eca_cl_t     pf_cl;
   logic        vfy_ee;
   logic        vfy_pf;
   logic        two_phase;
   logic        key_ok;
   // Concurrency check.
   eca_cl_t     op_ee;
   eca_cl_t     op_pf;
   eca_cl_t     pf_rd_cl;
   logic        pf_ok;
   modport chk (input code, param, prot, special, clkdiv_ok,
                output access_error_flag, protection_violation_flag, ee_cl, pf_cl, vfy_ee, vfy_pf, two_phase, key_ok);
   modport col (input op_ee, op_pf, pf_rd_cl, output pf_ok);
   modport top (output code, param, prot, special, clkdiv_ok, op_ee, op_pf, pf_rd_cl,
                input access_error_flag, protection_violation_flag, ee_cl, pf_cl, vfy_ee, vfy_pf, two_phase, key_ok,
                pf_ok);
endinterface

// *** verilog/eca_pkg.sv ***
package eca_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFF_CLKDIV = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_CMD    = 8'h08;
   localparam logic [7:0] OFF_PARAM  = 8'h0C;
   localparam logic [7:0] OFF_PROT   = 8'h10;
   localparam logic [7:0] OFF_MODE   = 8'h14;
   localparam logic [7:0] OFF_RESULT = 8'h18;
   // Status bit positions.
   localparam int ST_DONE   = 7;
   localparam int ST_ACCESS_ERROR_FLAG = 5;
   localparam int ST_PROTECTION_VIOLATION_FLAG = 4;
   localparam int ST_VFAIL  = 0;
   // Protection bit positions.
   localparam int PR_LOWDIS  = 0;
   localparam int PR_HIGHDIS = 1;
   localparam int PR_PFOPEN  = 2;
   localparam int PR_EEOPEN  = 3;
   // Parameter field: bit 16 selects the EEPROM block for the block erase command.
   localparam int PA_EEBLK = 16;
   // Reset values and the override key.
   localparam logic [7:0]  CLKDIV_RST = 8'h00;
   localparam logic [3:0]  PROT_RST   = 4'h0;
   localparam logic [15:0] OVR_KEY    = 16'hA5C3;
   // Command codes.
   localparam logic [7:0] CMD_VFY_ALL = 8'h01;
   localparam logic [7:0] CMD_VFY_BLK = 8'h02;
   localparam logic [7:0] CMD_ERS_ALL = 8'h08;
   localparam logic [7:0] CMD_ERS_BLK = 8'h09;
   localparam logic [7:0] CMD_UNSEC   = 8'h0B;
   localparam logic [7:0] CMD_UMARGIN = 8'h0D;
   localparam logic [7:0] CMD_FMARGIN = 8'h0E;
   localparam logic [7:0] CMD_VFY_SEC = 8'h10;
   localparam logic [7:0] CMD_PRG_EE  = 8'h11;
   localparam logic [7:0] CMD_ERS_SEC = 8'h12;
   localparam logic [7:0] CMD_PROT_OV = 8'h13;
   // Operation classes used for the concurrency check.
   typedef logic [2:0] eca_cl_t;
   localparam eca_cl_t CL_NONE   = 3'h0;
   localparam eca_cl_t CL_READ   = 3'h1;
   localparam eca_cl_t CL_MARGIN = 3'h2;
   localparam eca_cl_t CL_PROG   = 3'h3;
   localparam eca_cl_t CL_SECT   = 3'h4;
   localparam eca_cl_t CL_MASS   = 3'h5;
   // Timing counts in clock cycles.
   localparam logic [5:0] SETUP_CYC = 6'h02;
   localparam logic [5:0] EXEC_CYC  = 6'h10;
   // Sequencer states.
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001,
      S_SETUP = 4'b0010,
      S_EXEC  = 4'b0100,
      S_VFY   = 4'b1000
   } eca_state_e;
endpackage

// *** verilog/eca_top.sv ***
`timescale 1ns/1ps
module eca_top (
   // Clock and reset.
   input  wire logic        REF_CLK_IN,
   input  wire logic        SYS_RST_IN,
   // APB slave.
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [7:0]  PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   // Memory read requests and erased-state reports from the arrays.
   input  wire logic        PF_RD_REQ_IN,
   input  wire logic        EE_RD_REQ_IN,
   input  wire logic        PF_ERASED_IN,
   input  wire logic        EE_ERASED_IN,
   // Read grants, collision and array operations.
   output logic             PF_RD_GNT_OUT,
   output logic             EE_RD_GNT_OUT,
   output logic             ILLEGAL_ACCESS_OUT,
   output eca_pkg::eca_cl_t EE_OP_OUT,
   output eca_pkg::eca_cl_t PF_OP_OUT,
   output logic             CMD_DONE_OUT
);
   import eca_pkg::*;

   eca_if ck ();

   eca_cmd_check eca_cmd_check_inst (
      .bus (ck)
   );

   eca_collide eca_collide_inst (
      .bus (ck)
   );

   logic [7:0]  clkdiv_q;
   logic        clkdiv_ok_q;
   logic [7:0]  command_code_q;
   logic [16:0] param_q;
   logic [3:0]  protect_q;
   logic        special_q;
   logic        override_q;
   logic [1:0]  margin_q;
   logic        done_q;
   logic        access_error_flag_q;
   logic        protection_violation_flag_q;
   logic        vfail_q;
   eca_state_e  state_q;
   logic [5:0]  cnt_q;
   eca_cl_t     op_ee_q;
   eca_cl_t     op_pf_q;
   logic        wr_en;
   logic        rd_en;
   logic        mapped;
   logic        launch;
   logic        launch_ok;
   logic        busy;
   logic        col_pf;
   logic        col_ee;
   logic        pf_can;
   logic        ee_can;
   logic        last_pf_q;
   logic        vfy_ee_q;
   logic        vfy_pf_q;
   logic        two_q;
   logic [3:0]  prot_eff;

   // One word per register; any other offset is answered with an error.
   function automatic logic is_mapped(input logic [7:0] a);
      return a == OFF_CLKDIV || a == OFF_STATUS || a == OFF_CMD || a == OFF_PARAM ||
             a == OFF_PROT || a == OFF_MODE || a == OFF_RESULT;
   endfunction

   // A transfer completes one cycle into its access phase.
   assign mapped = is_mapped(PADDR_IN);
   assign wr_en  = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && mapped;
   assign rd_en  = PSEL_IN && PENABLE_IN && !PREADY_OUT;

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT  <= 32'h0000_0000;
      end else begin
         PREADY_OUT  <= rd_en;
         PSLVERR_OUT <= rd_en && !mapped;
         PRDATA_OUT  <= 32'h0000_0000;
         if (rd_en && !PWRITE_IN) begin
            unique case (PADDR_IN)
               OFF_CLKDIV: PRDATA_OUT[7:0] <= clkdiv_q;
               OFF_STATUS: PRDATA_OUT[7:0] <= {done_q, 1'b0, access_error_flag_q,
                                               protection_violation_flag_q, 3'h0, vfail_q};
               OFF_CMD:    PRDATA_OUT[7:0] <= command_code_q;
               OFF_PARAM:  PRDATA_OUT[16:0] <= param_q;
               OFF_PROT:   PRDATA_OUT[4:0] <= {override_q, protect_q};
               OFF_MODE:   PRDATA_OUT[0] <= special_q;
               OFF_RESULT: PRDATA_OUT[9:0] <= {state_q, margin_q, 1'b0, op_ee_q};
               default:    PRDATA_OUT <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Setup registers; writes are refused while a command runs.
   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         clkdiv_q       <= CLKDIV_RST;
         clkdiv_ok_q    <= 1'b0;
         command_code_q <= 8'h00;
         param_q        <= 17'h0_0000;
         protect_q      <= PROT_RST;
         special_q      <= 1'b0;
      end else if (wr_en && done_q) begin
         if (PADDR_IN == OFF_CLKDIV) begin
            clkdiv_q    <= PWDATA_IN[7:0];
            clkdiv_ok_q <= 1'b1;
         end
         if (PADDR_IN == OFF_CMD) command_code_q <= PWDATA_IN[7:0];
         if (PADDR_IN == OFF_PARAM) param_q <= PWDATA_IN[16:0];
         if (PADDR_IN == OFF_PROT) protect_q <= PWDATA_IN[3:0];
         if (PADDR_IN == OFF_MODE) special_q <= PWDATA_IN[0];
      end
   end

   // Writing one to the complete bit while it is set is a launch request.
   assign launch    = wr_en && PADDR_IN == OFF_STATUS && PWDATA_IN[ST_DONE] && done_q;
   assign launch_ok = launch && !access_error_flag_q && !protection_violation_flag_q &&
                      !ck.access_error_flag && !ck.protection_violation_flag;
   assign prot_eff  = protect_q | {4{override_q}};

   // Feed the checkers; margin reads are classed apart from plain reads.
   always_comb begin
      ck.code      = command_code_q;
      ck.param     = param_q;
      ck.prot      = prot_eff;
      ck.special   = special_q;
      ck.clkdiv_ok = clkdiv_ok_q;
      ck.op_ee     = op_ee_q;
      ck.op_pf     = op_pf_q;
      ck.pf_rd_cl  = (margin_q != 2'h0) ? CL_MARGIN : CL_READ;
   end

   // Error flags hold until written with one; a new error beats the clear.
   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         access_error_flag_q         <= 1'b0;
         protection_violation_flag_q <= 1'b0;
      end else begin
         if (launch && (ck.access_error_flag || access_error_flag_q ||
                        protection_violation_flag_q)) begin
            access_error_flag_q <= 1'b1;
         end else if (wr_en && PADDR_IN == OFF_STATUS && PWDATA_IN[ST_ACCESS_ERROR_FLAG]) begin
            access_error_flag_q <= 1'b0;
         end
         if (launch && !ck.access_error_flag && !access_error_flag_q && ck.protection_violation_flag) begin
            protection_violation_flag_q <= 1'b1;
         end else if (wr_en && PADDR_IN == OFF_STATUS && PWDATA_IN[ST_PROTECTION_VIOLATION_FLAG]) begin
            protection_violation_flag_q <= 1'b0;
         end
      end
   end

   // Sequencer: a settling window with reads still served, then the array work.
   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         state_q  <= S_IDLE;
         cnt_q    <= 6'h00;
         done_q   <= 1'b1;
         op_ee_q  <= CL_NONE;
         op_pf_q  <= CL_NONE;
         vfy_ee_q <= 1'b0;
         vfy_pf_q <= 1'b0;
         two_q    <= 1'b0;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (launch_ok) begin
                  done_q   <= 1'b0;
                  state_q  <= S_SETUP;
                  cnt_q    <= SETUP_CYC;
                  vfy_ee_q <= ck.vfy_ee;
                  vfy_pf_q <= ck.vfy_pf;
                  two_q    <= ck.two_phase;
               end
            end
            S_SETUP: begin
               cnt_q <= cnt_q - 6'h01;
               if (cnt_q == 6'h01) begin
                  state_q <= S_EXEC;
                  cnt_q   <= EXEC_CYC;
                  op_ee_q <= ck.ee_cl;
                  op_pf_q <= ck.pf_cl;
               end
            end
            S_EXEC: begin
               cnt_q <= cnt_q - 6'h01;
               if (cnt_q == 6'h01) begin
                  if (two_q) begin
                     state_q <= S_VFY;
                     cnt_q   <= EXEC_CYC;
                     op_ee_q <= CL_READ;
                     op_pf_q <= CL_READ;
                  end else begin
                     state_q <= S_IDLE;
                     done_q  <= 1'b1;
                     op_ee_q <= CL_NONE;
                     op_pf_q <= CL_NONE;
                  end
               end
            end
            S_VFY: begin
               cnt_q <= cnt_q - 6'h01;
               if (cnt_q == 6'h01) begin
                  state_q <= S_IDLE;
                  done_q  <= 1'b1;
                  op_ee_q <= CL_NONE;
                  op_pf_q <= CL_NONE;
               end
            end
         endcase
      end
   end

   // Results recorded as the array work ends.
   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         vfail_q    <= 1'b0;
         margin_q   <= 2'h0;
         override_q <= 1'b0;
      end else begin
         if (launch_ok) begin
            vfail_q <= 1'b0;
         end else if ((state_q == S_EXEC && !two_q || state_q == S_VFY) &&
                      cnt_q == 6'h01) begin
            vfail_q <= (vfy_ee_q && !EE_ERASED_IN) ||
                       (vfy_pf_q && !PF_ERASED_IN);
            if (command_code_q == CMD_UMARGIN || command_code_q == CMD_FMARGIN) begin
               margin_q <= param_q[1:0];
            end
            if (command_code_q == CMD_PROT_OV) begin
               override_q <= ck.key_ok;
            end
         end
      end
   end

   // Collisions count only while the array is really working.
   assign busy   = state_q == S_EXEC || state_q == S_VFY;
   assign col_pf = PF_RD_REQ_IN && busy && !ck.pf_ok;
   assign col_ee = EE_RD_REQ_IN && busy && op_ee_q != CL_NONE;
   assign pf_can = PF_RD_REQ_IN && !col_pf;
   assign ee_can = EE_RD_REQ_IN && !col_ee;

   // One read per cycle; on contention the memory not served last goes first.
   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         PF_RD_GNT_OUT      <= 1'b0;
         EE_RD_GNT_OUT      <= 1'b0;
         ILLEGAL_ACCESS_OUT <= 1'b0;
         last_pf_q          <= 1'b0;
      end else begin
         PF_RD_GNT_OUT      <= pf_can && (!ee_can || !last_pf_q);
         EE_RD_GNT_OUT      <= ee_can && (!pf_can || last_pf_q);
         ILLEGAL_ACCESS_OUT <= col_pf || col_ee;
         if (pf_can && ee_can) last_pf_q <= !last_pf_q;
         else if (pf_can || ee_can) last_pf_q <= pf_can;
      end
   end

   // Array operation outputs follow the sequencer registers.
   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         EE_OP_OUT    <= CL_NONE;
         PF_OP_OUT    <= CL_NONE;
         CMD_DONE_OUT <= 1'b1;
      end else begin
         EE_OP_OUT    <= op_ee_q;
         PF_OP_OUT    <= op_pf_q;
         CMD_DONE_OUT <= done_q;
      end
   end

   chk_collide_flag: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (PF_RD_REQ_IN && busy && !ck.pf_ok) |=> ILLEGAL_ACCESS_OUT && !PF_RD_GNT_OUT)
      else $error("collision not flagged");
   chk_flag_cycle_only: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (!PF_RD_REQ_IN && !EE_RD_REQ_IN) |=> !ILLEGAL_ACCESS_OUT)
      else $error("illegal access outside operation");
   chk_setup_reads: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (state_q == S_SETUP && PF_RD_REQ_IN && !EE_RD_REQ_IN) |=> PF_RD_GNT_OUT)
      else $error("read not served before array start");
   chk_one_read: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      !(PF_RD_GNT_OUT && EE_RD_GNT_OUT))
      else $error("two reads granted");
   chk_bad_code: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (launch && command_code_q == 8'h05)
      |=> access_error_flag_q && done_q && state_q == S_IDLE)
      else $error("bad code not rejected");
   chk_div_first: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (launch && !clkdiv_ok_q && command_code_q == CMD_PRG_EE) |=> access_error_flag_q ##1
      state_q == S_IDLE)
      else $error("write ran without divider");
   chk_mass_guard: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (launch && clkdiv_ok_q && !access_error_flag_q && !protection_violation_flag_q &&
       command_code_q == CMD_ERS_ALL && !(&prot_eff)) |=> protection_violation_flag_q && done_q)
      else $error("mass erase not guarded");
   chk_launch_done: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      launch_ok |=> !done_q ##[18:40] done_q)
      else $error("command did not complete in time");
   chk_flags_block: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (launch && access_error_flag_q) |=> state_q == S_IDLE && access_error_flag_q)
      else $error("launch accepted with error flag set");
   chk_ee_busy: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (EE_RD_REQ_IN && busy && op_ee_q != CL_NONE) |=> ILLEGAL_ACCESS_OUT && !EE_RD_GNT_OUT)
      else $error("busy EEPROM read not flagged");

   // Launch preconditions that software can get wrong; each refusal leaves complete set.
   chk_field_margin: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (launch && command_code_q == CMD_FMARGIN && !special_q)
      |=> access_error_flag_q && done_q)
      else $error("field margin accepted outside special mode");
   chk_prog_count: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (launch && command_code_q == CMD_PRG_EE && (param_q[2:0] == 3'h0 || param_q[2:0] > 3'h4))
      |=> access_error_flag_q && done_q)
      else $error("bad word count accepted");

   // Results and overlaps of accepted commands.
   chk_unsec_phases: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (launch_ok && command_code_q == CMD_UNSEC) |=> !done_q ##33 !done_q ##1 done_q)
      else $error("unsecure did not run erase and verify");
   chk_override_key: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      ($rose(done_q) && command_code_q == CMD_PROT_OV)
      |-> override_q == (param_q[15:0] == OVR_KEY))
      else $error("override does not follow key");
   chk_pf_read_ok: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (PF_RD_REQ_IN && !EE_RD_REQ_IN && busy && op_pf_q == CL_NONE && margin_q == 2'h0 &&
       (op_ee_q == CL_READ || op_ee_q == CL_PROG || op_ee_q == CL_SECT)) |=> PF_RD_GNT_OUT)
      else $error("allowed program flash read refused");

   // Scenarios that every regression should reach.
   cov_launch: cover property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) launch_ok);
   cov_collide: cover property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) col_pf);
   cov_overlap: cover property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      PF_RD_REQ_IN && busy && op_ee_q == CL_PROG);
   cov_unsec: cover property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) state_q == S_VFY);
   cov_override: cover property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) override_q);
endmodule
